// ### rtl/ifm_pkg.sv
/*
 * Constants, register indices and state type for the pin period and
 * frequency measurement block.
 * Assumes a single core clock; all timing counts derive from its rate.
 */
package ifm_pkg;

   // ==========================================================
   // clock and timing
   localparam int unsigned CORE_HZ     = 20_000_000;
   localparam int unsigned CLK_NS      = 50;
   localparam int unsigned TICK_DIV    = 2;
   localparam int unsigned SERVICE_NS  = 14_000;
   localparam int unsigned SERVICE_CYC = (SERVICE_NS / CLK_NS) < 1 ? 1 : SERVICE_NS / CLK_NS;
   localparam int unsigned MAX_SPAN_S  = 107;
   localparam int unsigned DIV_ITER    = 64;

   // ==========================================================
   // register indices
   localparam int unsigned REG_AW             = 4;
   localparam logic [3:0]  IDX_FEATURE_ENABLE = 4'h0;
   localparam logic [3:0]  IDX_FEATURE_SELECT = 4'h1;
   localparam logic [3:0]  IDX_MODE_OPTIONS   = 4'h2;
   localparam logic [3:0]  IDX_AVERAGE_COUNT  = 4'h3;
   localparam logic [3:0]  IDX_PERIOD_TICKS   = 4'h4;
   localparam logic [3:0]  IDX_TOTAL_TICKS    = 4'h5;
   localparam logic [3:0]  IDX_PERIOD_SECONDS = 4'h6;
   localparam logic [3:0]  IDX_FREQUENCY_HZ   = 4'h7;
   localparam logic [3:0]  IDX_PERIOD_TCLR    = 4'h8;
   localparam logic [3:0]  IDX_PERIOD_SCLR    = 4'h9;

   // ==========================================================
   // fields and reset values
   localparam logic [31:0] FEATURE_IDX    = 32'h0000000b;
   localparam logic [31:0] ENABLE_ON      = 32'h00000001;
   localparam int unsigned MODE_EDGE_BIT  = 0;
   localparam int unsigned MODE_CONT_BIT  = 1;
   localparam logic [31:0] ENABLE_RESET   = 32'h0;
   localparam logic [31:0] SELECT_RESET   = 32'h0;
   localparam logic [31:0] MODE_RESET     = 32'h0;
   localparam logic [31:0] AVERAGE_RESET  = 32'h0;
   localparam int unsigned STREAM_BITS    = 16;
   localparam int          FLOAT_BIAS     = 127;

   typedef enum logic [3:0] {
      IFM_IDLE, IFM_EDGE, IFM_AVG_LD, IFM_AVG_W, IFM_PER_LD, IFM_PER_W,
      IFM_FRQ_LD, IFM_FRQ_W, IFM_HOLD
   } ifm_state_t;

endpackage : ifm_pkg

// ### rtl/ifm_top.sv
/*
 * Per-pin period and frequency measurement with edge servicing.
 * Assumes pins are asynchronous to ref_clk_i and software reaches the
 * registers through the indexed read/write port, one channel at a time.
 */
`timescale 1ns/10ps
module ifm_top #(
   parameter int unsigned NUM_CH       = 6,
   parameter int unsigned CORE_RATE_HZ = ifm_pkg::CORE_HZ
) (
   input  wire logic                       ref_clk_i,
   input  wire logic                       rst_i,
   input  wire logic [NUM_CH-1:0]          pin_i,
   input  wire logic                       reg_wr_i,
   input  wire logic                       reg_rd_i,
   input  wire logic [7:0]                 reg_ch_i,
   input  wire logic [ifm_pkg::REG_AW-1:0] reg_addr_i,
   input  wire logic [31:0]                reg_wdata_i,
   input  wire logic                       stream_i,
   output logic      [31:0]                reg_rdata_o,
   output logic                            reg_ack_o,
   output logic      [15:0]                capture_hi_o,
   output logic      [NUM_CH-1:0]          pending_o
);
   import ifm_pkg::*;

   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (rst_i);

   localparam int unsigned CHW      = (NUM_CH > 1) ? $clog2(NUM_CH) : 1;
   localparam int unsigned TICK_HZ  = CORE_RATE_HZ / TICK_DIV;
   localparam logic [8:0]  SVC_LAST = 9'(SERVICE_CYC - 1);

   // ==========================================================
   // helpers
   function automatic logic ifm_active(input logic [31:0] en, input logic [31:0] sel);
      return (en == ENABLE_ON) && (sel == FEATURE_IDX);
   endfunction : ifm_active

   function automatic logic ifm_is_period(input logic [3:0] a);
      return (a == IDX_PERIOD_TICKS) || (a == IDX_PERIOD_SECONDS) ||
             (a == IDX_PERIOD_TCLR) || (a == IDX_PERIOD_SCLR);
   endfunction : ifm_is_period

   function automatic logic ifm_is_clear(input logic [3:0] a);
      return (a == IDX_PERIOD_TCLR) || (a == IDX_PERIOD_SCLR);
   endfunction : ifm_is_clear

   function automatic logic [6:0] ifm_msb(input logic [63:0] v);
      logic [6:0] m;
      m = 7'h0;
      for (int i = 0; i < 64; i++) begin
         if (v[i]) begin
            m = 7'(i);
         end
      end
      return m;
   endfunction : ifm_msb

   function automatic logic [23:0] ifm_mant(input logic [63:0] v);
      logic [63:0] sh;
      sh = v << (7'h3f - ifm_msb(v));
      return sh[63:40];
   endfunction : ifm_mant

   // quotient of two left-aligned mantissas scaled by 2^24
   function automatic logic [31:0] ifm_pack(input logic [63:0] q, input logic [6:0] ea,
                                            input logic [6:0] eb);
      int          e;
      logic [22:0] frac;
      e = FLOAT_BIAS + int'(ea) - int'(eb);
      if (q[24]) begin
         frac = q[23:1];
      end else begin
         frac = q[22:0];
         e    = e - 1;
      end
      return {1'b0, 8'(e), frac};
   endfunction : ifm_pack

   function automatic logic [CHW-1:0] ifm_first(input logic [NUM_CH-1:0] v);
      logic [CHW-1:0] r;
      r = '0;
      for (int i = NUM_CH - 1; i >= 0; i--) begin
         if (v[i]) begin
            r = CHW'(i);
         end
      end
      return r;
   endfunction : ifm_first

   // ==========================================================
   // declarations
   logic [NUM_CH-1:0] s1_r, s2_r, s3_r, lvl_r, edge_w, pend_r, dir_r;
   logic [NUM_CH-1:0] started_r, done_r;
   logic [31:0]       ts_r [NUM_CH];
   logic [31:0]       last_r [NUM_CH];
   logic [31:0]       acc_r [NUM_CH];
   logic [31:0]       cnt_r [NUM_CH];
   logic [31:0]       en_r [NUM_CH];
   logic [31:0]       sel_r [NUM_CH];
   logic [31:0]       mode_r [NUM_CH];
   logic [31:0]       avg_r [NUM_CH];
   logic [31:0]       per_r [NUM_CH];
   logic [31:0]       pfl_r [NUM_CH];
   logic [31:0]       frq_r [NUM_CH];
   logic [31:0]       tot_last_r [NUM_CH];
   logic [31:0]       tot_cap_r [NUM_CH];
   logic              half_r;
   logic [31:0]       tick_r;
   ifm_state_t        st_r;
   logic [CHW-1:0]    svc_ch_r;
   logic [8:0]        svc_cnt_r;
   logic              svc_done;
   logic [63:0]       op_a_r, op_b_r;
   logic [31:0]       op_n_r, res_avg_r, res_per_r;
   logic [63:0]       num_r, quo_r;
   logic [31:0]       den_r, rem_r;
   logic [6:0]        div_cnt_r;
   logic              div_load;
   logic [63:0]       div_num_in;
   logic [31:0]       div_den_in;
   logic [32:0]       rem_s, rem_d;
   logic              commit;
   logic              ch_ok, rd_period, rd_clear;
   logic [CHW-1:0]    rch;
   logic [31:0]       n_eff, span, acc_new, cnt_new, rd_val;
   logic              applic, do_start, do_acc, do_pub;

   // ==========================================================
   // pin synchroniser, filter and pending flags
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         s1_r  <= '0;
         s2_r  <= '0;
         s3_r  <= '0;
         lvl_r <= '0;
      end else begin
         s1_r <= pin_i;
         s2_r <= s1_r;
         s3_r <= s2_r;
         for (int c = 0; c < NUM_CH; c++) begin
            if (edge_w[c]) begin
               lvl_r[c] <= s3_r[c];
            end
         end
      end
   end

   // both directions raise a pending edge
   assign edge_w = ~(s2_r ^ s3_r) & (s3_r ^ lvl_r);

   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         pend_r <= '0;
         dir_r  <= '0;
         for (int c = 0; c < NUM_CH; c++) begin
            ts_r[c] <= 32'h0;
         end
      end else begin
         for (int c = 0; c < NUM_CH; c++) begin
            // set wins over the service clear; otherwise the edge is dropped
            if (edge_w[c] && (!pend_r[c] || (svc_done && svc_ch_r == CHW'(c)))) begin
               pend_r[c] <= 1'b1;
               dir_r[c]  <= s3_r[c];
               ts_r[c]   <= tick_r;
            end else if (svc_done && svc_ch_r == CHW'(c)) begin
               pend_r[c] <= 1'b0;
            end
         end
      end
   end

   assign pending_o = pend_r;

   // ==========================================================
   // tick counter at half the core rate
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         half_r <= 1'b0;
         tick_r <= 32'h0;
      end else begin
         half_r <= ~half_r;
         if (half_r) begin
            tick_r <= tick_r + 32'h1;
         end
      end
   end

   // ==========================================================
   // service decision for the channel in hand
   always_comb begin
      n_eff    = (avg_r[svc_ch_r] == 32'h0) ? 32'h1 : avg_r[svc_ch_r];
      span     = ts_r[svc_ch_r] - last_r[svc_ch_r];
      acc_new  = acc_r[svc_ch_r] + span;
      cnt_new  = cnt_r[svc_ch_r] + 32'h1;
      applic   = ifm_active(en_r[svc_ch_r], sel_r[svc_ch_r]) && !done_r[svc_ch_r] &&
                 (dir_r[svc_ch_r] == mode_r[svc_ch_r][MODE_EDGE_BIT]);
      do_start = (st_r == IFM_EDGE) && applic && !started_r[svc_ch_r];
      do_acc   = (st_r == IFM_EDGE) && applic && started_r[svc_ch_r];
      do_pub   = do_acc && (cnt_new >= n_eff);
   end

   // ==========================================================
   // service sequencer
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         st_r      <= IFM_IDLE;
         svc_ch_r  <= '0;
         svc_cnt_r <= 9'h0;
         op_a_r    <= 64'h0;
         op_b_r    <= 64'h0;
         op_n_r    <= 32'h1;
         res_avg_r <= 32'h0;
         res_per_r <= 32'h0;
      end else begin
         svc_cnt_r <= (st_r == IFM_IDLE) ? 9'h0 : svc_cnt_r + 9'h1;
         case (st_r)
            IFM_IDLE: begin
               if (|pend_r) begin
                  svc_ch_r <= ifm_first(pend_r);
                  st_r     <= IFM_EDGE;
               end
            end
            IFM_EDGE: begin
               if (do_pub && acc_new != 32'h0) begin
                  op_a_r <= {32'h0, acc_new};
                  op_b_r <= 64'(TICK_HZ) * {32'h0, n_eff};
                  op_n_r <= n_eff;
                  st_r   <= IFM_AVG_LD;
               end else begin
                  st_r <= IFM_HOLD;
               end
            end
            IFM_AVG_LD: st_r <= IFM_AVG_W;
            IFM_AVG_W: begin
               if (div_cnt_r == 7'h0) begin
                  res_avg_r <= quo_r[31:0];
                  st_r      <= IFM_PER_LD;
               end
            end
            IFM_PER_LD: st_r <= IFM_PER_W;
            IFM_PER_W: begin
               if (div_cnt_r == 7'h0) begin
                  res_per_r <= ifm_pack(quo_r, ifm_msb(op_a_r), ifm_msb(op_b_r));
                  st_r      <= IFM_FRQ_LD;
               end
            end
            IFM_FRQ_LD: st_r <= IFM_FRQ_W;
            IFM_FRQ_W: begin
               if (div_cnt_r == 7'h0) begin
                  st_r <= IFM_HOLD;
               end
            end
            IFM_HOLD: begin
               if (svc_cnt_r == SVC_LAST) begin
                  st_r <= IFM_IDLE;
               end
            end
            default: st_r <= IFM_IDLE;
         endcase
      end
   end

   assign svc_done = (st_r == IFM_HOLD) && (svc_cnt_r == SVC_LAST);
   assign commit   = (st_r == IFM_FRQ_W) && (div_cnt_r == 7'h0);

   // ==========================================================
   // shared restoring divider
   always_comb begin
      div_load   = 1'b0;
      div_num_in = {32'h0, op_a_r[31:0]};
      div_den_in = op_n_r;
      case (st_r)
         IFM_AVG_LD: div_load = 1'b1;
         IFM_PER_LD: begin
            div_load   = 1'b1;
            div_num_in = {16'h0, ifm_mant(op_a_r), 24'h0};
            div_den_in = {8'h0, ifm_mant(op_b_r)};
         end
         IFM_FRQ_LD: begin
            div_load   = 1'b1;
            div_num_in = {16'h0, ifm_mant(op_b_r), 24'h0};
            div_den_in = {8'h0, ifm_mant(op_a_r)};
         end
         default: div_load = 1'b0;
      endcase
      rem_s = {rem_r, num_r[63]};
      rem_d = rem_s - {1'b0, den_r};
   end

   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         num_r     <= 64'h0;
         den_r     <= 32'h1;
         rem_r     <= 32'h0;
         quo_r     <= 64'h0;
         div_cnt_r <= 7'h0;
      end else if (div_load) begin
         num_r     <= div_num_in;
         den_r     <= div_den_in;
         rem_r     <= 32'h0;
         quo_r     <= 64'h0;
         div_cnt_r <= 7'(DIV_ITER);
      end else if (div_cnt_r != 7'h0) begin
         num_r     <= {num_r[62:0], 1'b0};
         div_cnt_r <= div_cnt_r - 7'h1;
         if (rem_s >= {1'b0, den_r}) begin
            rem_r <= rem_d[31:0];
            quo_r <= {quo_r[62:0], 1'b1};
         end else begin
            rem_r <= rem_s[31:0];
            quo_r <= {quo_r[62:0], 1'b0};
         end
      end
   end

   // ==========================================================
   // register port decode
   assign ch_ok     = reg_ch_i < 8'(NUM_CH);
   assign rch       = reg_ch_i[CHW-1:0];
   assign rd_period = reg_rd_i && ch_ok && ifm_is_period(reg_addr_i);
   assign rd_clear  = reg_rd_i && ch_ok && ifm_is_clear(reg_addr_i);

   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         for (int c = 0; c < NUM_CH; c++) begin
            en_r[c]   <= ENABLE_RESET;
            sel_r[c]  <= SELECT_RESET;
            mode_r[c] <= MODE_RESET;
            avg_r[c]  <= AVERAGE_RESET;
         end
      end else if (reg_wr_i && ch_ok) begin
         case (reg_addr_i)
            IDX_FEATURE_ENABLE: en_r[rch]   <= reg_wdata_i;
            IDX_FEATURE_SELECT: sel_r[rch]  <= reg_wdata_i;
            IDX_MODE_OPTIONS:   mode_r[rch] <= reg_wdata_i;
            IDX_AVERAGE_COUNT:  avg_r[rch]  <= reg_wdata_i;
            default: ;
         endcase
      end
   end

   // ==========================================================
   // measurement state per channel
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         started_r <= '0;
         done_r    <= '0;
         for (int c = 0; c < NUM_CH; c++) begin
            last_r[c] <= 32'h0;
            acc_r[c]  <= 32'h0;
            cnt_r[c]  <= 32'h0;
         end
      end else begin
         for (int c = 0; c < NUM_CH; c++) begin
            // disabled, or rearmed by a read: restart from a fresh first edge
            if (!ifm_active(en_r[c], sel_r[c]) || (rch == CHW'(c) && (rd_clear ||
                (rd_period && !mode_r[c][MODE_CONT_BIT])))) begin
               started_r[c] <= 1'b0;
               done_r[c]    <= 1'b0;
               acc_r[c]     <= 32'h0;
               cnt_r[c]     <= 32'h0;
            end
         end
         if (do_start) begin
            started_r[svc_ch_r] <= 1'b1;
            last_r[svc_ch_r]    <= ts_r[svc_ch_r];
         end
         if (do_acc) begin
            last_r[svc_ch_r] <= ts_r[svc_ch_r];
            acc_r[svc_ch_r]  <= do_pub ? 32'h0 : acc_new;
            cnt_r[svc_ch_r]  <= do_pub ? 32'h0 : cnt_new;
         end
         if (do_pub && !mode_r[svc_ch_r][MODE_CONT_BIT]) begin
            done_r[svc_ch_r]    <= 1'b1;
            started_r[svc_ch_r] <= 1'b0;
         end
      end
   end

   // ==========================================================
   // results and total capture
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         for (int c = 0; c < NUM_CH; c++) begin
            per_r[c]      <= 32'h0;
            pfl_r[c]      <= 32'h0;
            frq_r[c]      <= 32'h0;
            tot_last_r[c] <= 32'h0;
            tot_cap_r[c]  <= 32'h0;
         end
      end else begin
         if (rd_period) begin
            tot_cap_r[rch] <= tot_last_r[rch];
         end
         if (rd_clear) begin
            per_r[rch] <= 32'h0;
            pfl_r[rch] <= 32'h0;
            frq_r[rch] <= 32'h0;
         end
         // a new result overwrites, and wins over a same-cycle clear
         if (commit) begin
            per_r[svc_ch_r]      <= res_avg_r;
            pfl_r[svc_ch_r]      <= res_per_r;
            frq_r[svc_ch_r]      <= ifm_pack(quo_r, ifm_msb(op_b_r), ifm_msb(op_a_r));
            tot_last_r[svc_ch_r] <= op_a_r[31:0];
         end
      end
   end

   // ==========================================================
   // read data
   always_comb begin
      rd_val = 32'h0;
      if (ch_ok) begin
         case (reg_addr_i)
            IDX_FEATURE_ENABLE: rd_val = en_r[rch];
            IDX_FEATURE_SELECT: rd_val = sel_r[rch];
            IDX_MODE_OPTIONS:   rd_val = mode_r[rch];
            IDX_AVERAGE_COUNT:  rd_val = avg_r[rch];
            IDX_PERIOD_TICKS:   rd_val = per_r[rch];
            IDX_TOTAL_TICKS:    rd_val = tot_cap_r[rch];
            IDX_PERIOD_SECONDS: rd_val = pfl_r[rch];
            IDX_FREQUENCY_HZ:   rd_val = frq_r[rch];
            IDX_PERIOD_TCLR:    rd_val = per_r[rch];
            IDX_PERIOD_SCLR:    rd_val = pfl_r[rch];
            default:            rd_val = 32'h0;
         endcase
      end
   end

   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         reg_rdata_o  <= 32'h0;
         reg_ack_o    <= 1'b0;
         capture_hi_o <= 16'h0;
      end else begin
         reg_ack_o <= reg_rd_i;
         if (reg_rd_i) begin
            if (stream_i && (reg_addr_i == IDX_PERIOD_TICKS || reg_addr_i == IDX_TOTAL_TICKS ||
                             reg_addr_i == IDX_PERIOD_TCLR)) begin
               reg_rdata_o  <= {16'h0, rd_val[STREAM_BITS-1:0]};
               capture_hi_o <= rd_val[31:STREAM_BITS];
            end else begin
               reg_rdata_o <= rd_val;
            end
         end
      end
   end

   // ==========================================================
   // assertions
   sequence svc_begin_s;
      (st_r == IFM_IDLE) && (|pend_r) ##1 (st_r == IFM_EDGE);
   endsequence

   sequence int_stream_rd_s;
      reg_rd_i && stream_i && (reg_addr_i == IDX_PERIOD_TICKS) ##1 reg_ack_o;
   endsequence

   pend_set_a: assert property (edge_w[0] && !pend_r[0] |=> pend_r[0])
      else $error("edge did not raise pending flag");
   svc_time_a: assert property (svc_begin_s |-> ##(SERVICE_CYC) (st_r == IFM_IDLE))
      else $error("edge service length wrong");
   lost_edge_a: assert property (pend_r[0] && edge_w[0] && !(svc_done && svc_ch_r == '0)
                                 |=> $stable(ts_r[0]))
      else $error("edge queued while pending");
   svc_pend_a: assert property ((st_r != IFM_IDLE) |-> pend_r[svc_ch_r])
      else $error("service without pending flag");
   tick_rate_a: assert property (half_r |=> tick_r == $past(tick_r) + 32'h1)
      else $error("tick not at half core rate");
   wrong_edge_a: assert property ((st_r == IFM_EDGE) &&
                  (dir_r[svc_ch_r] != mode_r[svc_ch_r][MODE_EDGE_BIT]) |-> !do_acc && !do_start)
      else $error("wrong edge direction measured");
   avg_pub_a: assert property (do_pub |-> cnt_r[svc_ch_r] + 32'h1 >= n_eff)
      else $error("published before averaging finished");
   oneshot_idle_a: assert property ((st_r == IFM_EDGE) && done_r[svc_ch_r] |-> !do_pub)
      else $error("one-shot measured while idle");
   clear_zero_a: assert property (rd_clear && rch == '0 && !commit |=> per_r[0] == 32'h0)
      else $error("clearing read left result");
   cap_read_a: assert property (!$stable(tot_cap_r[0]) |-> $past(rd_period && rch == '0))
      else $error("total changed without period read");
   stream_lo_a: assert property (int_stream_rd_s |-> reg_rdata_o[31:16] == 16'h0)
      else $error("stream read upper half not zero");
   disable_a: assert property (!ifm_active(en_r[0], sel_r[0]) |=> !started_r[0])
      else $error("inactive channel still measuring");

endmodule : ifm_top

// ### test/ifm_pulse_src.sv
/* Square-wave source standing on a measured pin.
   Assumes run_i is steady while the bench waits for edges. */
`timescale 1ns/10ps
module ifm_pulse_src #(
   parameter int unsigned HALF_NS = 25_000
) (
   input  wire logic run_i,
   output logic      pin_o
);
   logic lvl = 1'b0;

   // ==========
   // waveform, idles low when stopped
   always begin
      #(HALF_NS);
      lvl = run_i ? ~lvl : 1'b0;
   end
   assign pin_o = lvl;
endmodule : ifm_pulse_src

// ### test/interrupt_frequency_input_bench.sv
/* Self-checking bench for ifm_top on pin 0.
   Assumes a 50 ns core clock and a 1000-cycle source period. */
`timescale 1ns/10ps
module interrupt_frequency_input_bench;
   import ifm_pkg::*;
   logic        ref_clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        run = 1'b0;
   logic        src;
   logic        reg_wr_i = 1'b0;
   logic        reg_rd_i = 1'b0;
   logic        stream_i = 1'b0;
   logic [3:0]  reg_addr_i = 4'h0;
   logic [31:0] reg_wdata_i = 32'h0;
   logic [31:0] reg_rdata_o;
   logic        reg_ack_o;
   logic [15:0] capture_hi_o;
   logic [5:0]  pending_o;
   int          fails = 0;
   int          check_count = 0;

   always #25 ref_clk_i = ~ref_clk_i;
   ifm_pulse_src u_src (.run_i(run), .pin_o(src));
   ifm_top dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .pin_i({5'h00, src}),
      .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_ch_i(8'h00),
      .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .stream_i(stream_i),
      .reg_rdata_o(reg_rdata_o), .reg_ack_o(reg_ack_o),
      .capture_hi_o(capture_hi_o), .pending_o(pending_o));

   // ==========
   // shared tasks
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         fails++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(negedge ref_clk_i);
      reg_addr_i = a;
      reg_wdata_i = d;
      reg_wr_i = 1'b1;
      @(negedge ref_clk_i);
      reg_wr_i = 1'b0;
   endtask : wr
   task automatic rd(input logic [3:0] a, input logic [31:0] exp);
      @(negedge ref_clk_i);
      reg_addr_i = a;
      reg_rd_i = 1'b1;
      @(negedge ref_clk_i);
      reg_rd_i = 1'b0;
      chk({31'h0, reg_ack_o}, 32'h1);
      chk(reg_rdata_o, exp);
   endtask : rd

   // ==========
   // scenarios
   task automatic t_reset;
      rd(IDX_MODE_OPTIONS, MODE_RESET);
      rd(IDX_AVERAGE_COUNT, AVERAGE_RESET);
   endtask : t_reset
   task automatic t_oneshot;
      int n;
      wr(IDX_FEATURE_SELECT, FEATURE_IDX);
      wr(IDX_MODE_OPTIONS, 32'h1);
      wr(IDX_FEATURE_ENABLE, ENABLE_ON);
      run = 1'b1;
      for (n = 0; n < 1500 && pending_o[0] !== 1'b1; n++) @(negedge ref_clk_i);
      chk({31'h0, pending_o[0]}, 32'h1);
      repeat (3000) @(negedge ref_clk_i);
      rd(IDX_PERIOD_TICKS, 32'd500);
      rd(IDX_TOTAL_TICKS, 32'd500);
      rd(IDX_FREQUENCY_HZ, 32'h469c4000);
      rd(IDX_PERIOD_SECONDS, 32'h3851b717);
      rd(IDX_PERIOD_TICKS, 32'd500);
   endtask : t_oneshot
   task automatic t_clear;
      rd(IDX_PERIOD_TCLR, 32'd500);
      rd(IDX_PERIOD_TICKS, 32'd0);
      rd(IDX_TOTAL_TICKS, 32'd500);
      repeat (3000) @(negedge ref_clk_i);
      rd(IDX_PERIOD_TICKS, 32'd500);
   endtask : t_clear
   task automatic t_average;
      wr(IDX_AVERAGE_COUNT, 32'h2);
      rd(IDX_PERIOD_TCLR, 32'd500);
      repeat (4500) @(negedge ref_clk_i);
      stream_i = 1'b1;
      rd(IDX_PERIOD_TICKS, 32'd500);
      chk({16'h0, capture_hi_o}, 32'h0);
      stream_i = 1'b0;
      rd(IDX_TOTAL_TICKS, 32'd1000);
   endtask : t_average
   task automatic t_cont;
      wr(IDX_AVERAGE_COUNT, AVERAGE_RESET);
      wr(IDX_MODE_OPTIONS, 32'h3);
      repeat (3000) @(negedge ref_clk_i);
      rd(IDX_PERIOD_SCLR, 32'h3851b717);
      rd(IDX_PERIOD_TICKS, 32'd0);
      rd(IDX_TOTAL_TICKS, 32'd500);
      repeat (3000) @(negedge ref_clk_i);
      rd(IDX_PERIOD_TICKS, 32'd500);
      rd(IDX_TOTAL_TICKS, 32'd500);
      wr(IDX_FEATURE_ENABLE, 32'h0);
      rd(IDX_PERIOD_TCLR, 32'd500);
      repeat (3000) @(negedge ref_clk_i);
      rd(IDX_PERIOD_TICKS, 32'd0);
   endtask : t_cont

   task automatic finish_test;
      $display("checks=%0d fails=%0d", check_count, fails);
      if (fails == 0 && check_count > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : finish_test

   initial begin
      repeat (2) @(posedge ref_clk_i);
      @(negedge ref_clk_i);
      rst_i = 1'b0;
      t_reset();
      t_oneshot();
      t_clear();
      t_average();
      t_cont();
      finish_test();
   end
   initial begin
      #1_500_000;
      fails++;
      finish_test();
   end
endmodule : interrupt_frequency_input_bench
